/* File: design/fci_pkg.sv */
// Constants for the flash command host controller
package fci_pkg;
  // Bus and word widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  // Command addresses (low 11 bits significant)
  localparam logic [10:0] CMD_ADDR_A = 11'h555;
  localparam logic [10:0] CMD_ADDR_B = 11'h2AA;
  // Command data bytes
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
  // Identification read offsets (A1:A0)
  localparam logic [1:0] ID_MAKER = 2'h0;
  localparam logic [1:0] ID_PART = 2'h1;
  localparam logic [1:0] ID_PROTECT = 2'h2;
  localparam int BLK_LSB = 16;
  // Operation codes from the user side
  localparam logic [3:0] OP_RESET1 = 4'h0;
  localparam logic [3:0] OP_RESET3 = 4'h1;
  localparam logic [3:0] OP_AUTOSEL = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_BYPASS = 4'h4;
  localparam logic [3:0] OP_BYP_PROG = 4'h5;
  localparam logic [3:0] OP_BYP_EXIT = 4'h6;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h7;
  localparam logic [3:0] OP_BLK_ERASE = 4'h8;
  localparam logic [3:0] OP_SUSPEND = 4'h9;
  localparam logic [3:0] OP_RESUME = 4'hA;
  localparam logic [3:0] OP_READ = 4'hB;
  localparam logic [3:0] OP_ID_READ = 4'hC;
  localparam logic [3:0] OP_BLK_ADD = 4'hD;
  // Bus timing, 20 MHz clock
  localparam int CLK_NS = 50;
  localparam int SETUP_NS = 50;
  localparam int STROBE_NS = 100;
  localparam int READ_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_MAX = 6;
  localparam logic [3:0] SETUP_C = 4'(SETUP_CYC);
  localparam logic [3:0] STROBE_C = 4'(STROBE_CYC);
  localparam logic [3:0] READ_C = 4'(READ_CYC);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_READ = 5'b10000
  } fci_state_t;
endpackage

/* File: design/fci_host.sv */
// Host side sequencer that issues flash command bus cycles
//
// What this block and the flash do
// [RL1] Any broken sequence drops the flash to read mode; host never interleaves commands.
// [RL2] Reset is one F0 write, or AA@555, 55@2AA, F0.
// [RL3] After reset during erase or error, flash needs 10us to abort before reads; host adds no wait.
// [RL4] Identification entry is AA@555, 55@2AA, 90@555; mode persists.
// [RL5] Id read with A1:A0=00 gives maker code, 01 gives part code.
// [RL6] Id read with A1:A0=10 and A18:A16 block gives protection byte.
// [RL7] Program is AA@555, 55@2AA, A0@555, then value at target.
// [RL8] Program into protected block is silently dropped by the flash.
// [RL9] Flash ignores commands and shows status while programming.
// [RL10] Flash returns to read mode after program, or holds status on error.
// [RL11] Programming only clears bits; only erase sets them.
// [RL12] AA@555, 55@2AA, 20@555 enters bypass mode.
// [RL13] Bypass program is A0 at any address, then value at target.
// [RL14] Reset after a bypass program error keeps the flash in bypass.
// [RL15] Bypass exit is 90 then 00, each at any address.
// [RL16] Flash keeps per-block protection, reported by identification read.
// [RL17] Chip erase is six writes ending 10@555.
// [RL18] Block erase is five writes plus 30 at block; more within 50us.
// [RL19] B0 suspends block erase within 15us; 30 resumes it.
// [RL20] Flash compares only address bits 0 to 10 of commands.
// [RL21] Step index walks command writes and finishes at the last step.
`timescale 1ns/1ns
module fci_host
  import fci_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  // User command port
  input wire logic cmdValid,
  input wire logic [3:0] cmdOp,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [DATA_W-1:0] cmdData,
  output logic cmdReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  // Flash pins
  output logic chipEnable_n,
  output logic outputEnable_n,
  output logic writeEnable_n,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [DATA_W-1:0] flashDout,
  output logic flashDoe,
  input wire logic [DATA_W-1:0] flashDin
);

  // ----------------------------------------
  // Command table
  // ----------------------------------------
  // Length of each operation in bus writes; zero means a read
  function automatic logic [2:0] op_len(input logic [3:0] op);
    case (op)
      OP_RESET1, OP_SUSPEND, OP_RESUME, OP_BLK_ADD: op_len = 3'd1;
      OP_RESET3, OP_AUTOSEL, OP_BYPASS: op_len = 3'd3;
      OP_PROGRAM: op_len = 3'd4;
      OP_BYP_PROG, OP_BYP_EXIT: op_len = 3'd2;
      OP_CHIP_ERASE, OP_BLK_ERASE: op_len = 3'd6;
      default: op_len = 3'd0;
    endcase
  endfunction

  // Address and data of write number idx of an operation
  function automatic logic [ADDR_W+DATA_W-1:0] op_word(input logic [3:0] op,
      input logic [2:0] idx, input logic [ADDR_W-1:0] ua, input logic [DATA_W-1:0] ud);
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    a = ADDR_W'(CMD_ADDR_A);
    d = CMD_UNLOCK1;
    if (idx == 3'd1 || idx == 3'd4) begin
      a = ADDR_W'(CMD_ADDR_B);
      d = CMD_UNLOCK2;
    end
    case (op)
      OP_RESET1: begin
        a = ua; // RL2
        d = CMD_RESET;
      end
      OP_RESET3: if (idx == 3'd2) d = CMD_RESET; // RL2
      OP_AUTOSEL: if (idx == 3'd2) d = CMD_AUTOSEL; // RL4
      OP_BYPASS: if (idx == 3'd2) d = CMD_BYPASS; // RL12
      OP_PROGRAM: begin
        if (idx == 3'd2) d = CMD_PROGRAM; // RL7
        if (idx == 3'd3) begin
          a = ua;
          d = ud;
        end
      end
      OP_BYP_PROG: begin
        a = ua; // RL13
        d = (idx == 3'd0) ? CMD_PROGRAM : ud;
      end
      OP_BYP_EXIT: begin
        a = ua; // RL15
        d = (idx == 3'd0) ? CMD_AUTOSEL : CMD_BYPASS_EXIT;
      end
      OP_CHIP_ERASE, OP_BLK_ERASE: begin
        if (idx == 3'd2) d = CMD_ERASE_SETUP; // RL17
        if (idx == 3'd5) begin
          if (op == OP_CHIP_ERASE) begin
            d = CMD_CHIP_ERASE;
          end else begin
            a = ua; // RL18
            d = CMD_BLOCK_ERASE;
          end
        end
      end
      OP_BLK_ADD: begin
        a = ua; // RL18
        d = CMD_BLOCK_ERASE;
      end
      OP_SUSPEND: begin
        a = ua; // RL19
        d = CMD_SUSPEND;
      end
      OP_RESUME: begin
        a = ua; // RL19
        d = CMD_RESUME;
      end
      OP_ID_READ: d = ud;
      default: d = ud;
    endcase
    op_word = {a, d};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  fci_state_t state_q, state_d;
  logic [3:0] op_q;
  logic [ADDR_W-1:0] uAddr_q;
  logic [DATA_W-1:0] uData_q;
  logic [2:0] step_q;
  logic [3:0] cnt_q;
  logic [DATA_W-1:0] dinSync1_q, dinSync2_q;

  wire logic accept = cmdReady && cmdValid;
  wire logic [2:0] len = op_len(op_q);
  wire logic isRead = (len == 3'd0);
  wire logic lastStep = (step_q == len - 3'd1); // RL21
  wire logic cntDone = (cnt_q == 4'd0);
  // Values the request state takes at this edge, so pins change with the state
  wire logic [3:0] opNext = accept ? cmdOp : op_q;
  wire logic [ADDR_W-1:0] addrNext = accept ? cmdAddr : uAddr_q;
  wire logic [DATA_W-1:0] dataNext = accept ? cmdData : uData_q;
  wire logic stepUp = (state_q == ST_HOLD) && cntDone && !lastStep; // RL21
  wire logic [2:0] stepNext = accept ? 3'd0 : (stepUp ? step_q + 3'd1 : step_q);
  wire logic [ADDR_W+DATA_W-1:0] word = op_word(opNext, stepNext, addrNext, dataNext);
  // Id reads keep upper bits for the block select and force A1:A0
  wire logic [ADDR_W-1:0] idAddr = {addrNext[ADDR_W-1:2], dataNext[1:0]}; // RL5 RL6
  wire logic [ADDR_W-1:0] rdAddr = (opNext == OP_ID_READ) ? idAddr : addrNext;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (accept) state_d = (op_len(cmdOp) == 3'd0) ? ST_READ : ST_SETUP;
      ST_SETUP: if (cntDone) state_d = ST_STROBE;
      ST_STROBE: if (cntDone) state_d = ST_HOLD;
      ST_HOLD: if (cntDone) state_d = lastStep ? ST_IDLE : ST_SETUP; // RL1 RL21
      ST_READ: if (cntDone) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      op_q <= OP_READ;
      uAddr_q <= '0;
      uData_q <= '0;
      step_q <= 3'd0;
      cnt_q <= 4'd0;
    end else if (clkEn) begin
      state_q <= state_d;
      if (accept) begin
        op_q <= cmdOp;
        uAddr_q <= cmdAddr;
        uData_q <= cmdData;
      end
      if (state_d != state_q) begin
        cnt_q <= (state_d == ST_STROBE) ? STROBE_C - 4'd1 :
                 (state_d == ST_READ) ? READ_C + 4'd1 : SETUP_C - 4'd1;
      end else if (!cntDone) begin
        cnt_q <= cnt_q - 4'd1;
      end
      step_q <= stepNext; // RL21
    end
  end

  // Data inputs pass two flops before use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dinSync1_q <= '0;
      dinSync2_q <= '0;
    end else if (clkEn) begin
      dinSync1_q <= flashDin;
      dinSync2_q <= dinSync1_q;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  wire logic inWrite = (state_d == ST_SETUP) || (state_d == ST_STROBE) || (state_d == ST_HOLD);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmdReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= '0;
      chipEnable_n <= 1'b1;
      outputEnable_n <= 1'b1;
      writeEnable_n <= 1'b1;
      flashAddr <= '0;
      flashDout <= '0;
      flashDoe <= 1'b0;
    end else if (clkEn) begin
      cmdReady <= (state_d == ST_IDLE) && !accept;
      rspValid <= (state_q == ST_READ) && cntDone;
      if (state_q == ST_READ && cntDone) rspData <= dinSync2_q;
      chipEnable_n <= !(inWrite || state_d == ST_READ);
      outputEnable_n <= (state_d != ST_READ);
      writeEnable_n <= (state_d != ST_STROBE);
      flashDoe <= inWrite;
      if (inWrite) begin
        flashAddr <= word[ADDR_W+DATA_W-1:DATA_W];
        flashDout <= word[DATA_W-1:0];
      end else if (state_d == ST_READ) begin
        flashAddr <= rdAddr;
      end
    end
  end

endmodule // fci_host

/* File: verification/fci_host_monitor.sv */
// Checker of the host sequencer's pin and handshake timing
`timescale 1ns/1ns
module fci_host_monitor
  import fci_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // User command port
  input wire logic clkEn,
  input wire logic cmdValid,
  input wire logic [3:0] cmdOp,
  input wire logic cmdReady,
  input wire logic rspValid,
  // Flash pins
  input wire logic chipEnable_n,
  input wire logic outputEnable_n,
  input wire logic writeEnable_n,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [DATA_W-1:0] flashDout,
  input wire logic flashDoe
);
  wire logic take = clkEn && cmdValid && cmdReady;
  wire logic wr = !writeEnable_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_wr; wr |-> !chipEnable_n && outputEnable_n && flashDoe; endproperty
  a_wr: assert property (p_wr) else $error("write strobe form");
  property p_rd; !outputEnable_n |-> !flashDoe && !wr && !chipEnable_n; endproperty
  a_rd: assert property (p_rd) else $error("read strobe form");
  property p_idle; cmdReady |-> chipEnable_n && !wr && !flashDoe; endproperty
  a_idle: assert property (p_idle) else $error("pins busy while ready");
  property p_rsp; take && (cmdOp == OP_READ || cmdOp == OP_ID_READ) |-> ##5 rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("read answer late");
  property p_rst; take && cmdOp == OP_RESET1 |-> ##[1:3] (wr && flashDout == CMD_RESET); endproperty
  a_rst: assert property (p_rst) else $error("reset byte missing");
  property p_prg;
    take && cmdOp == OP_PROGRAM |->
      ##[1:3] (wr && flashDout == CMD_UNLOCK1 && flashAddr[10:0] == CMD_ADDR_A);
  endproperty
  a_prg: assert property (p_prg) else $error("program unlock missing");
  property p_byp; take && cmdOp == OP_BYP_PROG |-> ##[1:3] (wr && flashDout == CMD_PROGRAM); endproperty
  a_byp: assert property (p_byp) else $error("bypass program byte missing");
  property p_ext;
    take && cmdOp == OP_BYP_EXIT |->
      ##[1:3] (wr && flashDout == CMD_AUTOSEL) ##[1:8] (wr && flashDout == CMD_BYPASS_EXIT);
  endproperty
  a_ext: assert property (p_ext) else $error("bypass exit pair wrong");
endmodule // fci_host_monitor
bind fci_host fci_host_monitor u_mon (.clk_sys, .reset_n, .clkEn, .cmdValid, .cmdOp, .cmdReady,
  .rspValid, .chipEnable_n, .outputEnable_n, .writeEnable_n, .flashAddr, .flashDout, .flashDoe);

/* File: verification/fci_flash_model.sv */
// Behavioural flash device for the host sequencer bench
`timescale 1ns/1ns
module fci_flash_model
  import fci_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value
  parameter logic [7:0] PROT_MAP = 8'h04
) (
  // Flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] a,
  input wire logic [DATA_W-1:0] d,
  output logic [DATA_W-1:0] q
);
  logic [7:0] mem [16] = '{default: 8'hFF};
  logic [7:0] nWr = 8'h00;
  logic [7:0] lastD = 8'h00;
  logic [7:0] rd;
  int step = 0;
  bit idMode, byp, prog;
  wire logic hitA = a[10:0] == CMD_ADDR_A;
  wire logic hitB = a[10:0] == CMD_ADDR_B;
  always @(posedge we_n) begin
    if (!ce_n) begin
      nWr++;
      lastD = d;
      if (prog) begin
        if (!PROT_MAP[a[18:16]]) mem[a[3:0]] &= d;
        prog = 0;
      end else if (d == CMD_RESET) begin
        idMode = 0;
        step = 0;
      end else if (byp) begin
        prog = d == CMD_PROGRAM;
        if (step == 9 && d == CMD_BYPASS_EXIT) byp = 0;
        step = d == CMD_AUTOSEL ? 9 : 0;
      end else if ((step == 0 || step == 3) && hitA && d == CMD_UNLOCK1) step++;
      else if ((step == 1 || step == 4) && hitB && d == CMD_UNLOCK2) step++;
      else if (step == 2 && hitA) begin
        idMode = d == CMD_AUTOSEL;
        prog = d == CMD_PROGRAM;
        byp = d == CMD_BYPASS;
        step = d == CMD_ERASE_SETUP ? 3 : 0;
      end else begin
        if (step == 5 && (d == CMD_CHIP_ERASE || d == CMD_BLOCK_ERASE)) mem = '{default: 8'hFF};
        step = 0;
      end
    end
  end
  assign rd = idMode ? (a[1] ? {7'h00, PROT_MAP[a[18:16]]} : a[0] ? PART_CODE : MAKER_CODE)
                     : mem[a[3:0]];
  assign q = (!ce_n && !oe_n) ? rd : ~rd;
endmodule // fci_flash_model

/* File: verification/flash_command_interface_tb_top.sv */
// Testbench for the flash command host sequencer
`timescale 1ns/1ns
module flash_command_interface_tb_top;
  import fci_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cmdValid = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] cmdOp = 4'h0;
  logic [ADDR_W-1:0] cmdAddr = '0;
  logic [DATA_W-1:0] cmdData = '0;
  logic cmdReady, rspValid, chipEnable_n, outputEnable_n, writeEnable_n, flashDoe;
  logic [DATA_W-1:0] rspData, flashDout, devQ;
  logic [ADDR_W-1:0] flashAddr;
  wire logic [DATA_W-1:0] busD = flashDoe ? flashDout : devQ;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  fci_host dut (.clk_sys, .reset_n, .clkEn, .cmdValid, .cmdOp, .cmdAddr, .cmdData,
    .cmdReady, .rspValid, .rspData, .chipEnable_n, .outputEnable_n, .writeEnable_n, .flashAddr,
    .flashDout, .flashDoe, .flashDin(busD));
  fci_flash_model m (.ce_n(chipEnable_n), .oe_n(outputEnable_n), .we_n(writeEnable_n),
    .a(flashAddr), .d(busD), .q(devQ));
  task automatic results;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [3:0] o, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    while (cmdReady !== 1'b1) @(negedge clk_sys);
    cmdOp = o;
    cmdAddr = a;
    cmdData = d;
    cmdValid = 1'b1;
    @(posedge clk_sys);
    while (!(clkEn && cmdReady)) @(posedge clk_sys);
    @(negedge clk_sys);
    cmdValid = 1'b0;
    @(negedge clk_sys);
    while (cmdReady !== 1'b1) @(negedge clk_sys);
  endtask
  task automatic wop(input logic [3:0] o, input logic [ADDR_W-1:0] a, input logic [7:0] d,
      input logic [7:0] n, input logic [7:0] last);
    logic [7:0] b;
    b = m.nWr;
    op(o, a, d);
    chk(m.nWr - b, n);
    chk(m.lastD, last);
  endtask
  task automatic t_counts;
    wop(OP_RESET1, 19'h7_1234, 8'h00, 8'h01, CMD_RESET);
    wop(OP_RESET3, 19'h0_0000, 8'h00, 8'h03, CMD_RESET);
    wop(OP_AUTOSEL, 19'h0_0000, 8'h00, 8'h03, CMD_AUTOSEL);
    wop(OP_BYPASS, 19'h0_0000, 8'h00, 8'h03, CMD_BYPASS);
    wop(OP_BYP_PROG, 19'h0_0001, 8'h3C, 8'h02, 8'h3C);
    wop(OP_BYP_EXIT, 19'h0_0000, 8'h00, 8'h02, CMD_BYPASS_EXIT);
    wop(OP_PROGRAM, 19'h0_0002, 8'h7E, 8'h04, 8'h7E);
    wop(OP_CHIP_ERASE, 19'h0_0000, 8'h00, 8'h06, CMD_CHIP_ERASE);
    wop(OP_BLK_ERASE, 19'h1_0000, 8'h00, 8'h06, CMD_BLOCK_ERASE);
    wop(OP_BLK_ADD, 19'h3_0000, 8'h00, 8'h01, CMD_BLOCK_ERASE);
    wop(OP_SUSPEND, 19'h0_0000, 8'h00, 8'h01, CMD_SUSPEND);
    wop(OP_RESUME, 19'h0_0000, 8'h00, 8'h01, CMD_RESUME);
    wop(OP_RESET1, 19'h0_0000, 8'h00, 8'h01, CMD_RESET);
  endtask
  task automatic t_freeze;
    logic [7:0] b;
    b = m.nWr;
    clkEn = 1'b0;
    fork
      op(OP_RESET1, 19'h0_0000, 8'h00);
      begin
        repeat (8) @(negedge clk_sys);
        chk(m.nWr - b, 8'h00);
        chk({7'h00, chipEnable_n}, 8'h01);
        clkEn = 1'b1;
      end
    join
    chk(m.nWr - b, 8'h01);
  endtask
  task automatic t_ident;
    op(OP_AUTOSEL, 19'h0_0000, 8'h00);
    op(OP_ID_READ, 19'h0_0000, 8'h00);
    chk(rspData, m.MAKER_CODE);
    op(OP_ID_READ, 19'h0_0000, 8'h01);
    chk(rspData, m.PART_CODE);
    op(OP_ID_READ, 19'h2_0000, 8'h02);
    chk(rspData, 8'h01);
    op(OP_ID_READ, 19'h5_0000, 8'h02);
    chk(rspData, 8'h00);
    op(OP_RESET1, 19'h0_0000, 8'h00);
  endtask
  task automatic t_prog;
    op(OP_PROGRAM, 19'h4_0005, 8'hF3);
    op(OP_READ, 19'h4_0005, 8'h00);
    chk(rspData, 8'hF3);
    op(OP_PROGRAM, 19'h4_0005, 8'h3F);
    op(OP_READ, 19'h4_0005, 8'h00);
    chk(rspData, 8'h33);
    op(OP_PROGRAM, 19'h2_0006, 8'h00);
    op(OP_READ, 19'h0_0006, 8'h00);
    chk(rspData, 8'hFF);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    t_counts();
    t_ident();
    t_prog();
    t_freeze();
    results();
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
endmodule // flash_command_interface_tb_top
